// ===== core/dcp_comm_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_comm_cfg #(
  parameter int unsigned TENTH_CYC = dcp_pkg::TENTH_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic link_active,
  input wire logic telegram_valid,
  input wire logic [15:0] rx_process_word3,
  input wire logic [15:0] rx_process_word4,
  input wire dcp_pkg::dcp_meas_t meas,
  input wire logic first_digital_input,
  input wire logic second_digital_input,
  output logic [15:0] tx_process_word3,
  output logic [15:0] tx_process_word4,
  output logic [5:0] station_address_setting,
  output logic [7:0] variable_pointer,
  output logic [15:0] pointed_value_display,
  output logic ramp_source_select,
  output logic [15:0] ramp_time,
  output logic sensor_quick_stop_enable,
  output logic third_digital_output,
  output logic link_loss,
  output dcp_pkg::dcp_react_req_t react_req
);
  import dcp_pkg::*;
  logic [5:0] station_ff, nxt_station;
  logic [5:0] timeout_ff, nxt_timeout;
  dcp_react_t react_ff, nxt_react;
  logic ramp_src_ff, nxt_ramp_src;
  dcp_tx_sel_t tx3_ff, nxt_tx3, tx4_ff, nxt_tx4;
  dcp_rx_sel_t rx3_ff, nxt_rx3, rx4_ff, nxt_rx4;
  logic [7:0] ptr_ff, nxt_ptr;
  logic qstop_ff, nxt_qstop;
  logic [15:0] user_ff [4];
  logic [15:0] nxt_user [4];
  logic [31:0] rdata_ff, nxt_rdata;
  logic [2:0] din1_ff, din2_ff;
  logic [1:0] din_ff, nxt_din;
  logic [15:0] txw3_ff, nxt_txw3, txw4_ff, nxt_txw4;
  logic [15:0] ramp_ff, nxt_ramp;
  logic [15:0] pval_ff;
  logic loss;

  dcp_loss_watch #(
    .TENTH_CYC(TENTH_CYC)
  ) u_watch (
    .clk(clk),
    .rst_n(rst_n),
    .link_active(link_active),
    .telegram_valid(telegram_valid),
    .timeout_tenths(timeout_ff),
    .loss(loss)
  );

  // one mux serves both sent words
  function automatic logic [15:0] tx_pick(input dcp_tx_sel_t sel,
                                          input dcp_meas_t m,
                                          input logic [1:0] din,
                                          input logic [15:0] u1,
                                          input logic [15:0] u2);
    logic [15:0] w;
    w = 16'h0000;
    case (sel)
      DCP_TX_CURRENT: w = m.current_x10;
      DCP_TX_POWER: w = m.power_x100;
      DCP_TX_INPUTS: w = {14'h0000, din};
      DCP_TX_TEMP: w = m.temp_c;
      DCP_TX_USER1: w = u1;
      DCP_TX_USER2: w = u2;
      DCP_TX_POINTED: w = m.pointed_value;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  // settings writes: out-of-range values are dropped, old value kept; user 1 and 2 writes take wdata bits 15:0 unchecked
  always_comb begin
    nxt_station = station_ff;
    nxt_timeout = timeout_ff;
    nxt_react = react_ff;
    nxt_ramp_src = ramp_src_ff;
    nxt_tx3 = tx3_ff;
    nxt_tx4 = tx4_ff;
    nxt_rx3 = rx3_ff;
    nxt_rx4 = rx4_ff;
    nxt_ptr = ptr_ff;
    nxt_qstop = qstop_ff;
    nxt_user = user_ff;
    if (reg_wr) begin
      if (reg_addr == ADDR_STATION) begin
        if (reg_wdata[31:6] == 26'h0 && reg_wdata[5:0] >= STATION_MIN &&
            reg_wdata[5:0] <= STATION_MAX) begin
          nxt_station = reg_wdata[5:0];
        end
      end else if (reg_addr == ADDR_TIMEOUT) begin
        if (reg_wdata[31:6] == 26'h0 && reg_wdata[5:0] <= TIMEOUT_MAX) begin
          nxt_timeout = reg_wdata[5:0];
        end
      end else if (reg_addr == ADDR_REACTION) begin
        if (reg_wdata[31:2] == 30'h0) begin
          nxt_react = dcp_react_t'(reg_wdata[1:0]);
        end
      end else if (reg_addr == ADDR_RAMP_SRC) begin
        if (reg_wdata[31:1] == 31'h0) begin
          nxt_ramp_src = reg_wdata[0];
        end
      end else if (reg_addr == ADDR_TX3_SEL) begin
        if (reg_wdata[31:3] == 29'h0 && reg_wdata[2:0] <= TX_LAST) begin
          nxt_tx3 = dcp_tx_sel_t'(reg_wdata[2:0]);
        end
      end else if (reg_addr == ADDR_TX4_SEL) begin
        if (reg_wdata[31:3] == 29'h0 && reg_wdata[2:0] <= TX_LAST) begin
          nxt_tx4 = dcp_tx_sel_t'(reg_wdata[2:0]);
        end
      end else if (reg_addr == ADDR_RX3_SEL) begin
        if (reg_wdata[31:2] == 30'h0) begin
          nxt_rx3 = dcp_rx_sel_t'(reg_wdata[1:0]);
        end
      end else if (reg_addr == ADDR_RX4_SEL) begin
        if (reg_wdata[31:2] == 30'h0) begin
          nxt_rx4 = dcp_rx_sel_t'(reg_wdata[1:0]);
        end
      end else if (reg_addr == ADDR_POINTER) begin
        if (reg_wdata[31:8] == 24'h0 && reg_wdata[7:0] <= POINTER_MAX) begin
          nxt_ptr = reg_wdata[7:0];
        end
      end else if (reg_addr == ADDR_QSTOP) begin
        if (reg_wdata[31:1] == 31'h0) begin
          nxt_qstop = reg_wdata[0];
        end
      end else if (reg_addr == ADDR_USER1) begin
        nxt_user[0] = reg_wdata[15:0];
      end else if (reg_addr == ADDR_USER2) begin
        nxt_user[1] = reg_wdata[15:0];
      end
    end
    // user registers 3 and 4 are filled by the master only
    if (telegram_valid) begin
      if (rx3_ff == DCP_RX_USER3) begin
        nxt_user[2] = rx_process_word3;
      end else if (rx3_ff == DCP_RX_USER4) begin
        nxt_user[3] = rx_process_word3;
      end
      if (rx4_ff == DCP_RX_USER3) begin
        nxt_user[2] = rx_process_word4;
      end else if (rx4_ff == DCP_RX_USER4) begin
        nxt_user[3] = rx_process_word4;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      station_ff <= STATION_RST;
      timeout_ff <= TIMEOUT_RST;
      react_ff <= DCP_REACT_TRIP;
      ramp_src_ff <= 1'b0;
      tx3_ff <= TX3_RST;
      tx4_ff <= TX4_RST;
      rx3_ff <= RX3_RST;
      rx4_ff <= RX4_RST;
      ptr_ff <= POINTER_RST;
      qstop_ff <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        user_ff[i] <= 16'h0000;
      end
    end else begin
      station_ff <= nxt_station;
      timeout_ff <= nxt_timeout;
      react_ff <= nxt_react;
      ramp_src_ff <= nxt_ramp_src;
      tx3_ff <= nxt_tx3;
      tx4_ff <= nxt_tx4;
      rx3_ff <= nxt_rx3;
      rx4_ff <= nxt_rx4;
      ptr_ff <= nxt_ptr;
      qstop_ff <= nxt_qstop;
      user_ff <= nxt_user;
    end
  end

  // digital input pins: three stages, change taken when 2nd and 3rd agree
  always_comb begin
    nxt_din = din_ff;
    if (din1_ff[1] == din1_ff[2]) begin
      nxt_din[0] = din1_ff[2];
    end
    if (din2_ff[1] == din2_ff[2]) begin
      nxt_din[1] = din2_ff[2];
    end
  end

  // process words and ramp time; ramp word is kept when no ramp code
  always_comb begin
    nxt_txw3 = tx_pick(tx3_ff, meas, din_ff, user_ff[0], user_ff[1]);
    nxt_txw4 = tx_pick(tx4_ff, meas, din_ff, user_ff[0], user_ff[1]);
    nxt_ramp = ramp_ff;
    if (telegram_valid) begin
      // word 3 takes priority if both words carry ramp times
      if (rx3_ff == DCP_RX_RAMP) begin
        nxt_ramp = rx_process_word3;
      end else if (rx4_ff == DCP_RX_RAMP) begin
        nxt_ramp = rx_process_word4;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      din1_ff <= 3'h0;
      din2_ff <= 3'h0;
      din_ff <= 2'h0;
      txw3_ff <= 16'h0000;
      txw4_ff <= 16'h0000;
      ramp_ff <= 16'h0000;
      pval_ff <= 16'h0000;
    end else begin
      din1_ff <= {din1_ff[1:0], first_digital_input};
      din2_ff <= {din2_ff[1:0], second_digital_input};
      din_ff <= nxt_din;
      txw3_ff <= nxt_txw3;
      txw4_ff <= nxt_txw4;
      ramp_ff <= nxt_ramp;
      pval_ff <= meas.pointed_value;
    end
  end

  // read port: data stand in the cycle after the strobe only
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == ADDR_STATION) begin
        nxt_rdata = {26'h0, station_ff};
      end else if (reg_addr == ADDR_TIMEOUT) begin
        nxt_rdata = {26'h0, timeout_ff};
      end else if (reg_addr == ADDR_REACTION) begin
        nxt_rdata = {30'h0, react_ff};
      end else if (reg_addr == ADDR_RAMP_SRC) begin
        nxt_rdata = {31'h0, ramp_src_ff};
      end else if (reg_addr == ADDR_TX3_SEL) begin
        nxt_rdata = {29'h0, tx3_ff};
      end else if (reg_addr == ADDR_TX4_SEL) begin
        nxt_rdata = {29'h0, tx4_ff};
      end else if (reg_addr == ADDR_RX3_SEL) begin
        nxt_rdata = {30'h0, rx3_ff};
      end else if (reg_addr == ADDR_RX4_SEL) begin
        nxt_rdata = {30'h0, rx4_ff};
      end else if (reg_addr == ADDR_POINTER) begin
        nxt_rdata = {24'h0, ptr_ff};
      end else if (reg_addr == ADDR_QSTOP) begin
        nxt_rdata = {31'h0, qstop_ff};
      end else if (reg_addr == ADDR_STATUS) begin
        nxt_rdata = {29'h0, din_ff, loss};
      end else if (reg_addr == ADDR_USER1) begin
        nxt_rdata = {16'h0, user_ff[0]};
      end else if (reg_addr == ADDR_USER2) begin
        nxt_rdata = {16'h0, user_ff[1]};
      end else if (reg_addr == ADDR_USER3) begin
        nxt_rdata = {16'h0, user_ff[2]};
      end else if (reg_addr == ADDR_USER4) begin
        nxt_rdata = {16'h0, user_ff[3]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // reaction requests hold for as long as the loss condition holds
  always_comb begin
    react_req.trip = loss && (react_ff == DCP_REACT_TRIP ||
                              react_ff == DCP_REACT_RAMP_TRIP);
    react_req.ramp_stop = loss && (react_ff == DCP_REACT_RAMP_TRIP ||
                                   react_ff == DCP_REACT_RAMP);
    react_req.run_preset2 = loss && react_ff == DCP_REACT_PRESET2;
  end

  assign reg_rdata = rdata_ff;
  assign tx_process_word3 = txw3_ff;
  assign tx_process_word4 = txw4_ff;
  assign station_address_setting = station_ff;
  assign variable_pointer = ptr_ff;
  assign pointed_value_display = pval_ff;
  assign ramp_source_select = ramp_src_ff;
  assign ramp_time = ramp_ff;
  assign sensor_quick_stop_enable = qstop_ff;
  assign third_digital_output = qstop_ff;
  assign link_loss = loss;
endmodule
`default_nettype wire

// ===== core/dcp_pkg.sv
package dcp_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  // timeout is held in tenths of a second
  localparam int unsigned TENTH_MS = 100;
  localparam int unsigned TENTH_CYCLES = CLK_HZ / 1000 * TENTH_MS;
  localparam logic [7:0] ADDR_STATION = 8'h00;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
  localparam logic [7:0] ADDR_REACTION = 8'h08;
  localparam logic [7:0] ADDR_RAMP_SRC = 8'h0c;
  localparam logic [7:0] ADDR_TX3_SEL = 8'h10;
  localparam logic [7:0] ADDR_TX4_SEL = 8'h14;
  localparam logic [7:0] ADDR_RX3_SEL = 8'h18;
  localparam logic [7:0] ADDR_RX4_SEL = 8'h1c;
  localparam logic [7:0] ADDR_POINTER = 8'h20;
  localparam logic [7:0] ADDR_QSTOP = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  localparam logic [7:0] ADDR_USER1 = 8'h2c;
  localparam logic [7:0] ADDR_USER2 = 8'h30;
  localparam logic [7:0] ADDR_USER3 = 8'h34;
  localparam logic [7:0] ADDR_USER4 = 8'h38;
  localparam logic [5:0] STATION_MIN = 6'h01;
  localparam logic [5:0] STATION_MAX = 6'h3f;
  localparam logic [5:0] STATION_RST = 6'h01;
  localparam logic [5:0] TIMEOUT_MAX = 6'h32;
  localparam logic [5:0] TIMEOUT_RST = 6'h14;
  localparam logic [7:0] POINTER_MAX = 8'hc8;
  localparam logic [7:0] POINTER_RST = 8'h00;
  localparam int unsigned STATUS_LOSS_BIT = 0;
  localparam int unsigned STATUS_DIN_LSB = 1;
  typedef enum logic [1:0] {
    DCP_REACT_TRIP = 2'b00,
    DCP_REACT_RAMP_TRIP = 2'b01,
    DCP_REACT_RAMP = 2'b10,
    DCP_REACT_PRESET2 = 2'b11
  } dcp_react_t;
  typedef enum logic [2:0] {
    DCP_TX_CURRENT = 3'b000,
    DCP_TX_POWER = 3'b001,
    DCP_TX_INPUTS = 3'b010,
    DCP_TX_TEMP = 3'b011,
    DCP_TX_USER1 = 3'b100,
    DCP_TX_USER2 = 3'b101,
    DCP_TX_POINTED = 3'b110
  } dcp_tx_sel_t;
  localparam dcp_tx_sel_t TX_LAST = DCP_TX_POINTED;
  typedef enum logic [1:0] {
    DCP_RX_RESERVED = 2'b00,
    DCP_RX_RAMP = 2'b01,
    DCP_RX_USER3 = 2'b10,
    DCP_RX_USER4 = 2'b11
  } dcp_rx_sel_t;
  localparam dcp_tx_sel_t TX3_RST = DCP_TX_CURRENT;
  localparam dcp_tx_sel_t TX4_RST = DCP_TX_POWER;
  localparam dcp_rx_sel_t RX3_RST = DCP_RX_RAMP;
  localparam dcp_rx_sel_t RX4_RST = DCP_RX_RESERVED;
  // measurements from the drive core, already in word scaling
  typedef struct packed {
    logic [15:0] current_x10;
    logic [15:0] power_x100;
    logic [15:0] temp_c;
    logic [15:0] pointed_value;
  } dcp_meas_t;
  // reaction requests to the drive core, levels while loss holds
  typedef struct packed {
    logic trip;
    logic ramp_stop;
    logic run_preset2;
  } dcp_react_req_t;
endpackage

// ===== core/dcp_loss_watch.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_loss_watch #(
  parameter int unsigned TENTH_CYC = dcp_pkg::TENTH_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_active,
  input wire logic telegram_valid,
  input wire logic [5:0] timeout_tenths,
  output logic loss
);
  import dcp_pkg::*;
  localparam int unsigned PW = $clog2(TENTH_CYC + 1);
  // the prescaler needs at least two states to make a tick
  if (TENTH_CYC < 2) begin : g_bad_tenth
    $error("TENTH_CYC too small");
  end
  logic [PW-1:0] pre_ff, nxt_pre;
  logic [5:0] tenths_ff, nxt_tenths;
  logic loss_ff, nxt_loss;
  logic tick;
  always_comb begin
    tick = (pre_ff == PW'(TENTH_CYC - 1));
    nxt_pre = tick ? '0 : pre_ff + PW'(1);
    nxt_tenths = tenths_ff;
    nxt_loss = loss_ff;
    if (!link_active || timeout_tenths == 6'h00) begin
      // a zero timeout switches supervision off
      nxt_pre = '0;
      nxt_tenths = 6'h00;
      nxt_loss = 1'b0;
    end else begin
      // compare by order so a shortened timeout cannot wrap the count
      if (tick && tenths_ff < timeout_tenths) begin
        nxt_tenths = tenths_ff + 6'h01;
      end
      if (tenths_ff >= timeout_tenths && !loss_ff) begin
        nxt_loss = 1'b1;
      end else if (telegram_valid) begin
        nxt_loss = 1'b0;
      end
      if (telegram_valid) begin
        // expiry this cycle still sets loss; the restart follows
        nxt_pre = '0;
        nxt_tenths = 6'h00;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_ff <= '0;
      tenths_ff <= 6'h00;
      loss_ff <= 1'b0;
    end else begin
      pre_ff <= nxt_pre;
      tenths_ff <= nxt_tenths;
      loss_ff <= nxt_loss;
    end
  end
  assign loss = loss_ff;
endmodule
`default_nettype wire

// ===== verification/dcp_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_master_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] gap,
  input wire logic [15:0] w3,
  input wire logic [15:0] w4,
  output logic tg,
  output logic [15:0] rx3,
  output logic [15:0] rx4
);
  logic [7:0] cnt_ff, nxt_cnt;
  logic tg_ff, nxt_tg;
  logic [15:0] rx3_ff, rx4_ff, nxt_rx3, nxt_rx4;
  // words toggle between telegrams so stale data never passes as valid
  always_comb begin
    nxt_cnt = cnt_ff + 8'h01;
    nxt_tg = 1'b0;
    nxt_rx3 = ~rx3_ff;
    nxt_rx4 = ~rx4_ff;
    if (!run) begin
      nxt_cnt = 8'h00;
    end else if (cnt_ff >= gap) begin
      nxt_cnt = 8'h00;
      nxt_tg = 1'b1;
      nxt_rx3 = w3;
      nxt_rx4 = w4;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      tg_ff <= 1'b0;
      rx3_ff <= 16'h0000;
      rx4_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
      tg_ff <= nxt_tg;
      rx3_ff <= nxt_rx3;
      rx4_ff <= nxt_rx4;
    end
  end
  assign tg = tg_ff;
  assign rx3 = rx3_ff;
  assign rx4 = rx4_ff;
endmodule
`default_nettype wire

// ===== verification/dcp_comm_cfg_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_comm_cfg_sva #(
  parameter int unsigned TENTH_CYC = dcp_pkg::TENTH_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_active,
  input wire logic telegram_valid,
  input wire logic [5:0] station_address_setting,
  input wire logic [7:0] variable_pointer,
  input wire logic [15:0] ramp_time,
  input wire logic sensor_quick_stop_enable,
  input wire logic third_digital_output,
  input wire logic link_loss,
  input wire dcp_pkg::dcp_react_req_t react_req
);
  import dcp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  station_rng_a: assert property (
    station_address_setting != 6'h00) else $error("station zero");
  pointer_rng_a: assert property (
    variable_pointer <= 8'hc8) else $error("pointer above range");
  qstop_pin_a: assert property (
    third_digital_output == sensor_quick_stop_enable)
    else $error("quick stop pin differs");
  loss_link_a: assert property (
    !link_active |=> !link_loss) else $error("loss without link");
  // with a tenth of 4 or more cycles, no new loss can start 2 to 4 cycles after a telegram
  loss_restart_a: assert property (
    telegram_valid && link_active && TENTH_CYC >= 4
    |=> ##1 (!$rose(link_loss))[*3]) else $error("timer not restarted");
  react_idle_a: assert property (
    !link_loss |-> react_req == 3'b000) else $error("reaction without loss");
  react_kind_a: assert property (
    link_loss |-> react_req != 3'b000 && !(react_req.run_preset2 &&
    (react_req.trip || react_req.ramp_stop))) else $error("bad reaction");
  ramp_hold_a: assert property (
    $past(rst_n) && !$past(telegram_valid) |-> $stable(ramp_time))
    else $error("ramp time moved without telegram");
endmodule
bind dcp_comm_cfg dcp_comm_cfg_sva #(.TENTH_CYC(TENTH_CYC)) sva_u (
  .clk(clk), .rst_n(rst_n), .link_active(link_active),
  .telegram_valid(telegram_valid),
  .station_address_setting(station_address_setting),
  .variable_pointer(variable_pointer), .ramp_time(ramp_time),
  .sensor_quick_stop_enable(sensor_quick_stop_enable),
  .third_digital_output(third_digital_output), .link_loss(link_loss),
  .react_req(react_req));
`default_nettype wire

// ===== verification/drive_comm_parameter_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drive_comm_parameter_logic_tb;
  import dcp_pkg::*;
  logic clk, rst_n, reg_wr, reg_rd, link_active, tg, din1, din2, run;
  logic [7:0] reg_addr, gap, vptr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [15:0] rx3, rx4, w3, w4, tx3, tx4, pdisp, ramp_time;
  logic [5:0] station;
  logic rsel, qse, dq3, loss;
  dcp_meas_t meas;
  dcp_react_req_t react;
  int miscompares, comparisons, cycles, n;
  localparam int RSTV [10] = '{1, 20, 0, 0, 0, 1, 1, 0, 0, 0};
  localparam int REACT [4] = '{4, 6, 2, 1};
  // select code beside the word it must produce
  localparam logic [18:0] TXROW [7] = '{19'h00064, 19'h10190, 19'h20001,
    19'h3002d, 19'h400a1, 19'h500b2, 19'h61234};
  dcp_comm_cfg #(.TENTH_CYC(4)) dut_u (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_active(link_active),
    .telegram_valid(tg), .rx_process_word3(rx3), .rx_process_word4(rx4),
    .meas(meas), .first_digital_input(din1), .second_digital_input(din2),
    .tx_process_word3(tx3), .tx_process_word4(tx4),
    .station_address_setting(station), .variable_pointer(vptr),
    .pointed_value_display(pdisp), .ramp_source_select(rsel),
    .ramp_time(ramp_time), .sensor_quick_stop_enable(qse),
    .third_digital_output(dq3), .link_loss(loss), .react_req(react));
  dcp_master_model mst_u (.clk(clk), .rst_n(rst_n), .run(run), .gap(gap),
    .w3(w3), .w4(w4), .tg(tg), .rx3(rx3), .rx4(rx4));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic final_report();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, link_active, run, din2} = 5'h00;
    din1 = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    {gap, w3, w4} = 40'h0;
    meas = {16'h0064, 16'h0190, 16'h002d, 16'h1234};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    for (int i = 0; i < 10; i++) begin
      rd(8'(4 * i), 32'(RSTV[i]));
    end
    rd(8'h3c, 32'h0);
    wr(ADDR_STATION, 32'h0);
    wr(ADDR_STATION, 32'h40);
    rd(ADDR_STATION, 32'h1);
    wr(ADDR_STATION, 32'h3f);
    chk("station", 32'h3f, 32'(station));
    wr(ADDR_POINTER, 32'hc9);
    chk("pointer", 32'h0, 32'(vptr));
    wr(ADDR_POINTER, 32'hc8);
    chk("pointer", 32'hc8, 32'(vptr));
    chk("display", 32'h1234, 32'(pdisp));
    wr(ADDR_QSTOP, 32'h1);
    wr(ADDR_RAMP_SRC, 32'h1);
    chk("quick_stop", 32'h1, 32'(dq3));
    chk("quick_stop_en", 32'h1, 32'(qse));
    chk("ramp_src", 32'h1, 32'(rsel));
    wr(ADDR_USER1, 32'ha1);
    wr(ADDR_USER2, 32'hb2);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_TX3_SEL, 32'(TXROW[i][18:16]));
      wr(ADDR_TX4_SEL, 32'(TXROW[6 - i][18:16]));
      repeat (2) @(posedge clk);
      #1 chk("tx3", 32'(TXROW[i][15:0]), 32'(tx3));
      chk("tx4", 32'(TXROW[6 - i][15:0]), 32'(tx4));
    end
    wr(ADDR_TX3_SEL, 32'h7);
    rd(ADDR_TX3_SEL, 32'h6);
    wr(ADDR_TIMEOUT, 32'h1);
    w3 <= 16'd250;
    w4 <= 16'h5a5a;
    gap <= 8'h02;
    run <= 1'b1;
    link_active <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      #1 chk("loss", 32'h0, 32'(loss));
    end
    chk("ramp_time", 32'd250, 32'(ramp_time));
    wr(ADDR_RX3_SEL, 32'h2);
    wr(ADDR_RX4_SEL, 32'h3);
    repeat (8) @(posedge clk);
    #1 rd(ADDR_USER3, 32'd250);
    rd(ADDR_USER4, 32'h5a5a);
    run <= 1'b0;
    n = 0;
    while (loss !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    #1 chk("loss_delay", 32'h1, 32'(n >= 2 && n <= 9));
    // status: loss in bit 0, first input high, second low
    rd(ADDR_STATUS, 32'h3);
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_REACTION, 32'(r));
      chk("react", 32'(REACT[r]), 32'(react));
    end
    // the first telegram after a loss must clear it
    run <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("loss_clear", 32'h0, 32'(loss));
    run <= 1'b0;
    link_active <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk("loss", 32'h0, 32'(loss));
    chk("react", 32'h0, 32'(react));
    wr(ADDR_TIMEOUT, 32'h0);
    link_active <= 1'b1;
    repeat (30) @(posedge clk);
    #1 chk("loss", 32'h0, 32'(loss));
    final_report();
  end
endmodule
`default_nettype wire
